/* include/ax25_link_pkg.sv */
// constants, types and decode helpers for the link channel block
package ax25_link_pkg;

  // ****************************************************************
  // control codes
  // ****************************************************************
  localparam logic [7:0] CTRL_UI = 8'h03;
  localparam logic [7:0] CTRL_DM = 8'h0f;
  localparam logic [7:0] CTRL_CONN = 8'h2f;
  localparam logic [7:0] CTRL_DISC = 8'h43;
  localparam logic [7:0] CTRL_UACK = 8'h63;
  localparam logic [7:0] CTRL_FREJ = 8'h87;
  localparam logic [3:0] NIB_RR = 4'h1;
  localparam logic [3:0] NIB_RNR = 4'h5;
  localparam logic [3:0] NIB_REJ = 4'h9;
  localparam logic [7:0] FLAG_PATTERN = 8'h7e;

  // ****************************************************************
  // timing and flow limits
  // ****************************************************************
  localparam int CLK_NS = 40;
  localparam int TICK_NS = 10000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [3:0] PKT_LIMIT = 4'h7;
  localparam logic [10:0] IN_ROOM_MIN = 11'h0d2;
  localparam logic [10:0] RX_FRAME_MAX = 11'h100;
  localparam logic [15:0] LFSR_SEED = 16'hace1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_DEFER, ST_KEYUP, ST_SEND} tx_state_t;
  typedef enum logic [1:0] {SRC_RELAY, SRC_RESP, SRC_DATA} tx_src_t;
  typedef enum logic [3:0] {
    FK_INFO, FK_RR, FK_RNR, FK_REJ, FK_UI, FK_DM, FK_CONN, FK_DISC,
    FK_UACK, FK_FREJ, FK_BAD
  } frame_kind_t;

  function automatic frame_kind_t classify(input logic [7:0] c);
    frame_kind_t k;
    k = FK_BAD;
    if (!c[0]) begin
      k = FK_INFO;
    end else if (c[1:0] == 2'b01) begin
      if (c[3:0] == NIB_RR) k = FK_RR;
      else if (c[3:0] == NIB_RNR) k = FK_RNR;
      else if (c[3:0] == NIB_REJ) k = FK_REJ;
    end else if (c == CTRL_UI) k = FK_UI;
    else if (c == CTRL_DM) k = FK_DM;
    else if (c == CTRL_CONN) k = FK_CONN;
    else if (c == CTRL_DISC) k = FK_DISC;
    else if (c == CTRL_UACK) k = FK_UACK;
    else if (c == CTRL_FREJ) k = FK_FREJ;
    return k;
  endfunction

  // supervisory byte: expected number on top, poll bit clear
  function automatic logic [7:0] sup_ctrl(input logic [2:0] nr,
                                          input logic [3:0] nib);
    return {nr, 1'b0, nib};
  endfunction

endpackage

/* rtl/ax25_timebase.sv */
// common tick divider and free-running random source
`timescale 1ns/10ps
module ax25_timebase (
  input wire logic CLK_I,
  input wire logic RESET_I,
  output logic tick_o,
  output logic [3:0] rand_o
);

  typedef struct packed {
    logic [15:0] div;
    logic [15:0] lfsr;
    logic tick;
  } tb_state_t;

  localparam logic [15:0] DIV_LAST = 16'(ax25_link_pkg::TICK_CYCLES - 1);

  tb_state_t s_r;
  tb_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = (s_r.div == DIV_LAST);
    s_nxt.div = s_nxt.tick ? 16'h0000 : 16'(s_r.div + 16'h0001);
    // runs every cycle so the draw depends on when a backoff starts
    s_nxt.lfsr = {s_r.lfsr[14:0],
                  s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      s_r <= '0;
      s_r.lfsr <= ax25_link_pkg::LFSR_SEED;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;
  assign rand_o = s_r.lfsr[3:0];

endmodule

/* rtl/ax25_link_channel_access.sv */
// link control, channel access and flow control for the packet node
//
// Contract
// R1 - even control byte means information frame
// R2 - info byte holds own and expected numbers
// R3 - ack by receive-ready or piggybacked info frame
// R4 - receive-not-ready when no buffer space
// R5 - out-of-order number answered by reject
// R6 - connect code 2f, disconnect code 43
// R7 - connect or disconnect answered by ack 63
// R8 - disconnected: non-connect frames get mode 0f; the code leaves DM frames unanswered
// R9 - refused connect answered by disconnected mode
// R10 - undefined or improper byte gets frame reject
// R11 - unnumbered info never acknowledged
// R12 - key only while no carrier heard
// R13 - keyed without packet sends flag fill
// R14 - no ack within wait means resend
// R15 - retry waits random 0-15 keyup delays
// R16 - non-relay frames wait extra after clear
// R17 - relayed packets never acknowledged by relay
// R18 - acknowledgements wait the response delay first
// R19 - busy when next frame cannot fit
// R20 - hold host at 7 packets, <210 room
// R21 - ready again once buffers drain
// R22 - held sender resends; busy answer repeats
// R23 - sequence numbers modulo 8, <=7 outstanding
// R24 - flag pattern zero six ones zero
// R25 - backoff draws from free-running shift register
// R26 - timing settings counted in common ticks
`timescale 1ns/10ps
module ax25_link_channel_access (
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic ACCEPT_CONNECTS_I,
  input wire logic RELAY_MODE_I,
  input wire logic [7:0] KEYUP_DELAY_I,
  input wire logic [7:0] REPEATER_KEYUP_DELAY_I,
  input wire logic [7:0] ACK_WAIT_TIME_I,
  input wire logic [7:0] NON_RELAY_WAIT_I,
  input wire logic [7:0] ACK_RESPONSE_DELAY_I,
  input wire logic CARRIER_I,
  input wire logic RX_VALID_I,
  input wire logic [7:0] RX_CTRL_I,
  input wire logic RX_RELAY_I,
  input wire logic RX_SAME_PEER_I,
  input wire logic [10:0] RX_BUF_ROOM_I,
  input wire logic TX_REQ_I,
  input wire logic TX_DONE_I,
  input wire logic [3:0] TX_PKTS_BUILT_I,
  input wire logic [10:0] TX_IN_ROOM_I,
  output logic TX_KEY_O,
  output logic TX_FLAGS_O,
  output logic [7:0] TX_FLAG_BYTE_O,
  output logic TX_START_O,
  output logic [7:0] TX_CTRL_O,
  output logic TX_RELAY_O,
  output logic TX_ACKED_O,
  output logic RX_DELIVER_O,
  output logic LINK_UP_O,
  output logic RX_BUSY_O,
  output logic PEER_BUSY_O,
  output logic HOST_CTS_O,
  output logic HOST_XOFF_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    ax25_link_pkg::tx_state_t st;
    ax25_link_pkg::tx_src_t src;
    logic [12:0] cnt;
    logic retry;
    logic link;
    logic [2:0] vs;
    logic [2:0] vr;
    logic await;
    logic [7:0] ackt;
    logic resp_pend;
    logic [7:0] resp_ctrl;
    logic [7:0] respt;
    logic relay_pend;
    logic rx_busy;
    logic peer_busy;
    logic key;
    logic flags;
    logic start;
    logic [7:0] tx_ctrl;
    logic acked;
    logic deliver;
    logic hold;
    logic xoff;
  } link_state_t;

  link_state_t s_r;
  link_state_t s_nxt;
  logic tick;
  logic [3:0] rnd;

  ax25_timebase u_timebase (
    .CLK_I(CLK_I),
    .RESET_I(RESET_I),
    .tick_o(tick),
    .rand_o(rnd)
  );

  ax25_link_pkg::frame_kind_t kind;
  logic [2:0] rx_ns;
  logic [2:0] rx_nr;
  logic room_low;

  assign kind = ax25_link_pkg::classify(RX_CTRL_I); // [R1]
  assign rx_ns = RX_CTRL_I[3:1];
  assign rx_nr = RX_CTRL_I[7:5];
  assign room_low = RX_BUF_ROOM_I < ax25_link_pkg::RX_FRAME_MAX;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic pick;
    ax25_link_pkg::tx_src_t psrc;
    logic [12:0] wait_ld;
    logic [2:0] vr_new;
    logic resp_set;
    s_nxt = s_r;
    pick = 1'b0;
    resp_set = 1'b0;
    psrc = ax25_link_pkg::SRC_DATA;
    wait_ld = 13'h0000;
    vr_new = 3'(s_r.vr + 3'h1); // [R23]
    s_nxt.start = 1'b0;
    s_nxt.acked = 1'b0;
    s_nxt.deliver = 1'b0;

    if (tick && s_r.resp_pend && s_r.respt != 8'h00) begin
      s_nxt.respt = 8'(s_r.respt - 8'h01); // [R18] [R26]
    end

    // ack watchdog; expiry is taken as a collision
    if (tick && s_r.await) begin
      if (s_r.ackt == 8'h00) begin
        s_nxt.await = 1'b0;
        s_nxt.retry = 1'b1; // [R14] [R22]
      end else begin
        s_nxt.ackt = 8'(s_r.ackt - 8'h01);
      end
    end

    // buffers drained after a busy spell
    if (s_r.rx_busy && !room_low) begin
      s_nxt.rx_busy = 1'b0;
      s_nxt.resp_pend = 1'b1;
      s_nxt.resp_ctrl = ax25_link_pkg::sup_ctrl(s_r.vr,
                                                ax25_link_pkg::NIB_RR); // [R21]
      s_nxt.respt = ACK_RESPONSE_DELAY_I;
    end

    // ****************************************************************
    // received frames
    // ****************************************************************
    if (RX_VALID_I && RX_RELAY_I) begin
      if (RELAY_MODE_I) s_nxt.relay_pend = 1'b1; // [R17]
    end else if (RX_VALID_I) begin
      // every answer restarts the delay so a following packet is heard
      s_nxt.respt = ACK_RESPONSE_DELAY_I; // [R18]
      s_nxt.resp_pend = 1'b1;
      if (kind == ax25_link_pkg::FK_UI) begin
        s_nxt.deliver = 1'b1; // [R11]
        s_nxt.resp_pend = s_r.resp_pend;
        s_nxt.respt = s_r.respt;
      end else if (kind == ax25_link_pkg::FK_CONN) begin // [R6]
        if (ACCEPT_CONNECTS_I && (!s_r.link || RX_SAME_PEER_I)) begin
          s_nxt.link = 1'b1;
          s_nxt.vs = 3'h0;
          s_nxt.vr = 3'h0;
          s_nxt.await = 1'b0;
          s_nxt.retry = 1'b0;
          s_nxt.rx_busy = 1'b0;
          s_nxt.peer_busy = 1'b0;
          s_nxt.resp_ctrl = ax25_link_pkg::CTRL_UACK; // [R7]
        end else begin
          s_nxt.resp_ctrl = ax25_link_pkg::CTRL_DM; // [R9]
        end
      end else if (!s_r.link) begin
        // answering a mode frame with one would ping-pong forever
        if (kind == ax25_link_pkg::FK_DM) begin
          s_nxt.resp_pend = s_r.resp_pend;
          s_nxt.respt = s_r.respt;
        end else begin
          s_nxt.resp_ctrl = ax25_link_pkg::CTRL_DM; // [R8]
        end
      end else begin
        s_nxt.resp_pend = 1'b0;
        s_nxt.respt = s_r.respt;
        if (s_r.await && rx_nr == 3'(s_r.vs + 3'h1) &&
            (kind == ax25_link_pkg::FK_INFO ||
             kind == ax25_link_pkg::FK_RR ||
             kind == ax25_link_pkg::FK_RNR)) begin
          s_nxt.vs = 3'(s_r.vs + 3'h1); // [R3]
          s_nxt.await = 1'b0;
          s_nxt.retry = 1'b0;
          s_nxt.acked = 1'b1;
        end
        unique case (kind)
          ax25_link_pkg::FK_INFO: begin
            s_nxt.resp_pend = 1'b1;
            s_nxt.respt = ACK_RESPONSE_DELAY_I;
            if (room_low) begin
              s_nxt.rx_busy = 1'b1;
              s_nxt.resp_ctrl = ax25_link_pkg::sup_ctrl(s_r.vr,
                ax25_link_pkg::NIB_RNR); // [R4] [R19] [R22]
            end else if (rx_ns == s_r.vr) begin
              s_nxt.vr = vr_new;
              s_nxt.deliver = 1'b1;
              s_nxt.resp_ctrl = ax25_link_pkg::sup_ctrl(vr_new,
                ax25_link_pkg::NIB_RR); // [R3]
            end else begin
              s_nxt.resp_ctrl = ax25_link_pkg::sup_ctrl(s_r.vr,
                ax25_link_pkg::NIB_REJ); // [R5]
            end
          end
          ax25_link_pkg::FK_RR: s_nxt.peer_busy = 1'b0;
          ax25_link_pkg::FK_RNR: s_nxt.peer_busy = 1'b1;
          ax25_link_pkg::FK_REJ: begin
            s_nxt.peer_busy = 1'b0;
            if (rx_nr == s_r.vs && s_r.await) begin
              s_nxt.await = 1'b0;
              s_nxt.retry = 1'b1;
            end
          end
          ax25_link_pkg::FK_DISC: begin
            s_nxt.link = 1'b0;
            s_nxt.await = 1'b0;
            s_nxt.retry = 1'b0;
            s_nxt.resp_pend = 1'b1;
            s_nxt.respt = ACK_RESPONSE_DELAY_I;
            s_nxt.resp_ctrl = ax25_link_pkg::CTRL_UACK; // [R7]
          end
          ax25_link_pkg::FK_DM: begin
            s_nxt.link = 1'b0;
            s_nxt.await = 1'b0;
            s_nxt.retry = 1'b0;
          end
          ax25_link_pkg::FK_UACK, ax25_link_pkg::FK_FREJ: begin
          end
          default: begin
            s_nxt.resp_pend = 1'b1;
            s_nxt.respt = ACK_RESPONSE_DELAY_I;
            s_nxt.resp_ctrl = ax25_link_pkg::CTRL_FREJ; // [R10]
          end
        endcase
      end
    end

    // a response loaded now outlives the one that starts going out now
    resp_set = s_nxt.resp_pend &&
               ((s_r.rx_busy && !room_low) ||
                (RX_VALID_I && !RX_RELAY_I &&
                 kind != ax25_link_pkg::FK_UI &&
                 kind != ax25_link_pkg::FK_DM));

    // ****************************************************************
    // channel access
    // ****************************************************************
    if (s_r.relay_pend) begin
      pick = 1'b1;
      psrc = ax25_link_pkg::SRC_RELAY;
    end else if (s_r.resp_pend && s_r.respt == 8'h00) begin
      pick = 1'b1;
      psrc = ax25_link_pkg::SRC_RESP;
    end else if (s_r.link && (s_r.retry || (TX_REQ_I && !s_r.await))) begin
      pick = 1'b1;
      psrc = ax25_link_pkg::SRC_DATA;
    end
    if (!(psrc == ax25_link_pkg::SRC_RELAY && RELAY_MODE_I)) begin
      wait_ld = {5'h00, NON_RELAY_WAIT_I}; // [R16]
    end
    if (psrc == ax25_link_pkg::SRC_DATA && s_r.retry) begin
      wait_ld = 13'(wait_ld +
                    {9'h000, rnd} * {5'h00, KEYUP_DELAY_I}); // [R15] [R25]
    end

    unique case (s_r.st)
      ax25_link_pkg::ST_IDLE: begin
        s_nxt.key = 1'b0;
        s_nxt.flags = 1'b0;
        if (pick) begin
          s_nxt.st = ax25_link_pkg::ST_DEFER;
          s_nxt.src = psrc;
          s_nxt.cnt = wait_ld;
        end
      end
      ax25_link_pkg::ST_DEFER: begin
        // the full wait restarts whenever the channel goes busy
        if (CARRIER_I) begin
          s_nxt.cnt = wait_ld;
        end else if (tick) begin
          if (s_r.cnt == 13'h0000) begin
            s_nxt.st = ax25_link_pkg::ST_KEYUP; // [R12]
            s_nxt.key = 1'b1;
            s_nxt.flags = 1'b1; // [R13]
            s_nxt.cnt = 13'({1'b0, KEYUP_DELAY_I} +
                            {1'b0, REPEATER_KEYUP_DELAY_I});
          end else begin
            s_nxt.cnt = 13'(s_r.cnt - 13'h0001);
          end
        end
      end
      ax25_link_pkg::ST_KEYUP: begin
        if (tick) begin
          if (s_r.cnt == 13'h0000) begin
            s_nxt.st = ax25_link_pkg::ST_SEND;
            s_nxt.flags = 1'b0;
            s_nxt.start = 1'b1;
            unique case (s_r.src)
              ax25_link_pkg::SRC_RELAY: begin
                s_nxt.relay_pend = RX_VALID_I && RX_RELAY_I && RELAY_MODE_I;
                s_nxt.tx_ctrl = 8'h00;
              end
              ax25_link_pkg::SRC_RESP: begin
                s_nxt.resp_pend = resp_set;
                s_nxt.tx_ctrl = s_r.resp_ctrl;
              end
              default: begin
                s_nxt.tx_ctrl = {s_r.vr, 1'b0, s_r.vs, 1'b0}; // [R2]
                // the info frame carries the ack, so a plain ready is moot
                if (!resp_set &&
                    s_r.resp_ctrl[3:0] == ax25_link_pkg::NIB_RR) begin
                  s_nxt.resp_pend = 1'b0; // [R3]
                end
              end
            endcase
          end else begin
            s_nxt.cnt = 13'(s_r.cnt - 13'h0001);
          end
        end
      end
      ax25_link_pkg::ST_SEND: begin
        if (TX_DONE_I) begin
          s_nxt.st = ax25_link_pkg::ST_IDLE;
          s_nxt.key = 1'b0;
          if (s_r.src == ax25_link_pkg::SRC_DATA && s_r.link) begin
            s_nxt.await = 1'b1; // [R14]
            s_nxt.retry = 1'b0;
            s_nxt.ackt = ACK_WAIT_TIME_I;
          end
        end
      end
    endcase

    // ****************************************************************
    // host flow control
    // ****************************************************************
    s_nxt.hold = TX_PKTS_BUILT_I >= ax25_link_pkg::PKT_LIMIT &&
                 TX_IN_ROOM_I < ax25_link_pkg::IN_ROOM_MIN; // [R20]
    s_nxt.xoff = s_nxt.hold && !s_r.hold;
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign TX_KEY_O = s_r.key;
  assign TX_FLAGS_O = s_r.flags;
  assign TX_FLAG_BYTE_O = ax25_link_pkg::FLAG_PATTERN; // [R24]
  assign TX_START_O = s_r.start;
  assign TX_CTRL_O = s_r.tx_ctrl;
  assign TX_RELAY_O = s_r.src == ax25_link_pkg::SRC_RELAY;
  assign TX_ACKED_O = s_r.acked;
  assign RX_DELIVER_O = s_r.deliver;
  assign LINK_UP_O = s_r.link;
  assign RX_BUSY_O = s_r.rx_busy;
  assign PEER_BUSY_O = s_r.peer_busy;
  assign HOST_CTS_O = !s_r.hold;
  assign HOST_XOFF_O = s_r.xoff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  logic rx_own;
  assign rx_own = RX_VALID_I && !RX_RELAY_I;

  carrier_free_a: assert property ( // [R12]
    $rose(TX_KEY_O) |-> !$past(CARRIER_I))
    else $error("transmitter keyed over carrier");
  flag_fill_a: assert property ( // [R13]
    TX_KEY_O && s_r.st != ax25_link_pkg::ST_SEND |-> TX_FLAGS_O)
    else $error("keyed idle without flag fill");
  iframe_seq_a: assert property ( // [R2]
    TX_START_O && s_r.src == ax25_link_pkg::SRC_DATA
    |-> !TX_CTRL_O[0] && TX_CTRL_O[3:1] == s_r.vs)
    else $error("info frame number wrong");
  connect_ua_a: assert property ( // [R7]
    rx_own && RX_CTRL_I == ax25_link_pkg::CTRL_CONN && ACCEPT_CONNECTS_I
    && !s_r.link |=> LINK_UP_O && s_r.resp_pend
    && s_r.resp_ctrl == ax25_link_pkg::CTRL_UACK)
    else $error("connect not acknowledged");
  refuse_dm_a: assert property ( // [R9]
    rx_own && RX_CTRL_I == ax25_link_pkg::CTRL_CONN && !ACCEPT_CONNECTS_I
    |=> s_r.resp_ctrl == ax25_link_pkg::CTRL_DM && s_r.resp_pend)
    else $error("refused connect without mode reply");
  ui_quiet_a: assert property ( // [R11]
    rx_own && RX_CTRL_I == ax25_link_pkg::CTRL_UI && !s_r.rx_busy
    |=> $stable(s_r.resp_ctrl) && RX_DELIVER_O)
    else $error("unnumbered info answered");
  busy_rnr_a: assert property ( // [R19]
    rx_own && s_r.link && !RX_CTRL_I[0] && room_low
    |=> s_r.resp_ctrl[3:0] == ax25_link_pkg::NIB_RNR && RX_BUSY_O)
    else $error("full buffer not signalled busy");
  bad_frej_a: assert property ( // [R10]
    rx_own && s_r.link && kind == ax25_link_pkg::FK_BAD
    |=> s_r.resp_ctrl == ax25_link_pkg::CTRL_FREJ)
    else $error("undefined byte not rejected");
  relay_noack_a: assert property ( // [R17]
    RX_VALID_I && RX_RELAY_I && RELAY_MODE_I && !s_r.rx_busy
    |=> $stable(s_r.resp_ctrl) && s_r.relay_pend)
    else $error("relayed frame answered");
  host_hold_a: assert property ( // [R20]
    TX_PKTS_BUILT_I >= ax25_link_pkg::PKT_LIMIT
    && TX_IN_ROOM_I < ax25_link_pkg::IN_ROOM_MIN |=> !HOST_CTS_O)
    else $error("host not held");
  ack_retry_a: assert property ( // [R14]
    s_r.await && tick && s_r.ackt == 8'h00 && !RX_VALID_I |=> s_r.retry)
    else $error("no resend after ack wait");

  link_cov: cover property ($rose(LINK_UP_O));
  data_cov: cover property (TX_START_O && s_r.src == ax25_link_pkg::SRC_DATA);
  retry_cov: cover property (TX_START_O && s_r.retry);

endmodule

/* testbench/ax25_remote_node.sv */
// remote node model: frames toward the block, framer done, carrier
`timescale 1ns/10ps
module ax25_remote_node (
  input wire logic clk_i,
  input wire logic tx_start_i,
  input wire logic tx_key_i,
  input wire logic slow_i,
  output logic carrier_o,
  output logic rx_valid_o,
  output logic [7:0] rx_ctrl_o,
  output logic rx_relay_o,
  output logic rx_same_peer_o,
  output logic tx_done_o
);
  int gap;
  initial begin
    gap = 0;
    carrier_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_ctrl_o = 8'h00;
    rx_relay_o = 1'b0;
    rx_same_peer_o = 1'b0;
    tx_done_o = 1'b0;
  end
  // one frame per call; qualifiers scrambled once it is gone
  task automatic send(input logic [7:0] c, input logic same,
                      input logic rel);
    @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_ctrl_o <= c;
    rx_same_peer_o <= same;
    rx_relay_o <= rel;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_ctrl_o <= ~c;
    rx_same_peer_o <= ~same;
    rx_relay_o <= ~rel;
  endtask
  // half duplex: we only raise carrier while the block is unkeyed
  task automatic busy(input int n);
    while (tx_key_i === 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    carrier_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    carrier_o <= 1'b0;
  endtask
  // framer stand-in: done a few or many cycles after start
  always @(posedge clk_i) begin
    tx_done_o <= 1'b0;
    if (tx_start_i === 1'b1) begin
      gap <= slow_i ? 60 : 4;
    end else if (gap > 0) begin
      gap <= gap - 1;
      if (gap == 1) begin
        tx_done_o <= 1'b1;
      end
    end
  end
endmodule

/* testbench/ax25_link_channel_access_tb_top.sv */
// self-checking bench for the link channel block
`timescale 1ns/10ps
module ax25_link_channel_access_tb_top;
  localparam int TK = ax25_link_pkg::TICK_CYCLES;
  localparam int RS = 8;
  localparam int DS = 6;
  logic clk, rst, acc, rly, car, rxv, rxr, rxs, req, done, slow;
  logic key, flg, st, rel, ackd, dlv, up, rbusy, pbusy, cts, xoff;
  logic key_q, car_q;
  logic [7:0] rxc, fb, tctrl, kd, rd;
  logic [10:0] rxroom, inroom;
  logic [3:0] pkts;
  int num_errors, checks, cyc, vr, vs, dlv_n, ack_n, xoff_n;

  ax25_link_channel_access dut_u (.CLK_I(clk), .RESET_I(rst),
    .ACCEPT_CONNECTS_I(acc), .RELAY_MODE_I(rly),
    .KEYUP_DELAY_I(kd), .REPEATER_KEYUP_DELAY_I(8'h01),
    .ACK_WAIT_TIME_I(8'h02), .NON_RELAY_WAIT_I(8'h02),
    .ACK_RESPONSE_DELAY_I(rd), .CARRIER_I(car), .RX_VALID_I(rxv),
    .RX_CTRL_I(rxc), .RX_RELAY_I(rxr), .RX_SAME_PEER_I(rxs),
    .RX_BUF_ROOM_I(rxroom), .TX_REQ_I(req), .TX_DONE_I(done),
    .TX_PKTS_BUILT_I(pkts), .TX_IN_ROOM_I(inroom), .TX_KEY_O(key),
    .TX_FLAGS_O(flg), .TX_FLAG_BYTE_O(fb), .TX_START_O(st),
    .TX_CTRL_O(tctrl), .TX_RELAY_O(rel), .TX_ACKED_O(ackd),
    .RX_DELIVER_O(dlv), .LINK_UP_O(up), .RX_BUSY_O(rbusy),
    .PEER_BUSY_O(pbusy), .HOST_CTS_O(cts), .HOST_XOFF_O(xoff));

  ax25_remote_node partner_u (.clk_i(clk), .tx_start_i(st),
    .tx_key_i(key), .slow_i(slow), .carrier_o(car), .rx_valid_o(rxv),
    .rx_ctrl_o(rxc), .rx_relay_o(rxr), .rx_same_peer_o(rxs),
    .tx_done_o(done));

  // ****************************************************************
  // compare and wait helpers
  // ****************************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // counts tick jitter as two ticks of slack below the least wait
  task automatic expect_frame(input logic [7:0] exp, input int ticks);
    int n;
    n = 0;
    while (st !== 1'b1 && n < 12000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk8(tctrl, exp);
    chk1(n >= (ticks - 2) * TK && n < 12000, 1'b1);
    n = 0;
    while (key === 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic expect_none(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      chk1(st, 1'b0);
    end
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // clock, monitors, timeout
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    key_q <= key;
    car_q <= car;
    cyc++;
    if (dlv === 1'b1) dlv_n++;
    if (ackd === 1'b1) ack_n++;
    if (xoff === 1'b1) xoff_n++;
    if (key === 1'b1 && key_q === 1'b0) begin
      chk1(car_q, 1'b0);
      chk1(flg, 1'b1);
      chk8(fb, 8'h7e);
    end
    if (cyc == 100000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    acc = 1'b0;
    rly = 1'b0;
    req = 1'b0;
    slow = 1'b0;
    pkts = 4'h0;
    inroom = 11'h7ff;
    rxroom = 11'h7ff;
    {num_errors, checks, cyc, vr, vs, dlv_n, ack_n, xoff_n} = '0;
    void'($urandom(98));
    kd = 8'h02;
    // a longer response delay only lengthens the wait, so the least wait checked still holds
    rd = 8'(2 + $urandom_range(1, 0));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk1(up, 1'b0);
    chk1(cts, 1'b1);
    chk1(key, 1'b0);
    partner_u.send(8'h00, 1'b1, 1'b0);
    expect_frame(8'h0f, RS);
    partner_u.send(8'h03, 1'b1, 1'b0);
    expect_none(2500);
    chk8(8'(dlv_n), 8'h01);
    partner_u.send(8'h2f, 1'b1, 1'b0);
    expect_frame(8'h0f, RS);
    acc <= 1'b1;
    partner_u.send(8'h2f, 1'b1, 1'b0);
    fork
      partner_u.busy(900);
      expect_frame(8'h63, RS);
    join
    chk1(up, 1'b1);
    partner_u.send(8'h00, 1'b1, 1'b0);
    vr = 1;
    expect_frame({3'(vr), 1'b0, 4'h1}, RS);
    partner_u.send(8'h06, 1'b1, 1'b0);
    expect_frame({3'(vr), 1'b0, 4'h9}, RS);
    rxroom <= 11'h0ff;
    repeat (2) begin
      partner_u.send({4'h0, 3'(vr), 1'b0}, 1'b1, 1'b0);
      expect_frame({3'(vr), 1'b0, 4'h5}, RS);
      chk1(rbusy, 1'b1);
    end
    rxroom <= 11'h7ff;
    expect_frame({3'(vr), 1'b0, 4'h1}, RS);
    chk1(rbusy, 1'b0);
    partner_u.send({4'h0, 3'(vr), 1'b0}, 1'b1, 1'b0);
    vr = 2;
    expect_frame({3'(vr), 1'b0, 4'h1}, RS);
    chk8(8'(dlv_n), 8'h03);
    slow <= 1'b1;
    req <= 1'b1;
    expect_frame({3'(vr), 1'b0, 3'(vs), 1'b0}, DS);
    expect_frame({3'(vr), 1'b0, 3'(vs), 1'b0}, DS + 2);
    partner_u.send({3'(vs + 1), 1'b0, 4'h1}, 1'b1, 1'b0);
    req <= 1'b0;
    expect_none(3);
    chk8(8'(ack_n), 8'h01);
    vs = 1;
    slow <= 1'b0;
    partner_u.send({3'(vs), 1'b0, 4'h5}, 1'b1, 1'b0);
    @(posedge clk);
    #1;
    chk1(pbusy, 1'b1);
    partner_u.send({3'(vs), 1'b0, 4'h1}, 1'b1, 1'b0);
    @(posedge clk);
    #1;
    chk1(pbusy, 1'b0);
    partner_u.send(8'hff, 1'b1, 1'b0);
    expect_frame(8'h87, RS);
    rly <= 1'b1;
    partner_u.send(8'($urandom()), 1'b0, 1'b1);
    expect_frame(8'h00, 4);
    chk1(rel, 1'b1);
    expect_none(2500);
    rly <= 1'b0;
    partner_u.send(8'($urandom()), 1'b0, 1'b1);
    expect_none(2500);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pkts <= 4'(6 + i % 2);
      inroom <= 11'($urandom_range(209, 0));
      @(posedge clk);
      #1;
      chk1(cts, i % 2 == 0);
      inroom <= 11'($urandom_range(2047, 210));
      repeat (2) @(posedge clk);
      #1;
      chk1(cts, 1'b1);
    end
    chk8(8'(xoff_n), 8'h02);
    partner_u.send(8'h43, 1'b1, 1'b0);
    expect_frame(8'h63, RS);
    chk1(up, 1'b0);
    partner_u.send(8'h10, 1'b1, 1'b0);
    expect_frame(8'h0f, RS);
    give_verdict();
  end
endmodule
